// ### core/timer_async_pkg.sv
package timer_async_pkg;

  // ****************************************
  // Register word indices (byte address = 4 * index)
  // ****************************************
  localparam logic [7:0] IDX_IRQ_FLAGS = 8'h37;
  localparam logic [7:0] IDX_GENERAL_CTRL = 8'h43;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h70;
  localparam logic [7:0] IDX_CONTROL_A = 8'hb0;
  localparam logic [7:0] IDX_CONTROL_B = 8'hb1;
  localparam logic [7:0] IDX_COUNTER = 8'hb2;
  localparam logic [7:0] IDX_COMPARE_A = 8'hb3;
  localparam logic [7:0] IDX_COMPARE_B = 8'hb4;
  localparam logic [7:0] IDX_ASYNC_STATUS = 8'hb6;

  // ****************************************
  // Slots of the five asynchronously updated registers
  // ****************************************
  // Slot number equals the position of its busy bit in async_status
  localparam int SLOT_COUNTER = 4;
  localparam int SLOT_COMPARE_A = 3;
  localparam int SLOT_COMPARE_B = 2;
  localparam int SLOT_CONTROL_A = 1;
  localparam int SLOT_CONTROL_B = 0;

  // ****************************************
  // Field positions and write masks
  // ****************************************
  localparam int BIT_COMPARE_B = 2;
  localparam int BIT_COMPARE_A = 1;
  localparam int BIT_OVERFLOW = 0;
  localparam int BIT_SYNC_HOLD = 7;
  localparam int BIT_ASYNC_PRESCALER_RESET = 1;
  localparam int BIT_SYNC_PRESCALER_RESET = 0;
  localparam int BIT_EXT_CLOCK_ENABLE = 6;
  localparam int BIT_ASYNC_SELECT = 5;
  localparam int BIT_WGM_HIGH = 3;
  localparam logic [7:0] CONTROL_A_MASK = 8'hf3;
  localparam logic [7:0] CONTROL_B_MASK = 8'h0f;
  localparam logic [7:0] COUNTER_MAX = 8'hff;
  localparam logic [7:0] COUNTER_BOTTOM = 8'h00;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] RESET_REG = 8'h00;
  localparam logic [31:0] RESET_RDATA = 32'h0000_0000;

  // ****************************************
  // Clock select codes and prescaler tap masks
  // ****************************************
  localparam logic [2:0] CS_STOPPED = 3'h0;
  localparam logic [2:0] CS_DIRECT = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV32 = 3'h3;
  localparam logic [2:0] CS_DIV64 = 3'h4;
  localparam logic [2:0] CS_DIV128 = 3'h5;
  localparam logic [2:0] CS_DIV256 = 3'h6;
  localparam logic [2:0] CS_DIV1024 = 3'h7;
  localparam logic [9:0] TAP_DIV8 = 10'h007;
  localparam logic [9:0] TAP_DIV32 = 10'h01f;
  localparam logic [9:0] TAP_DIV64 = 10'h03f;
  localparam logic [9:0] TAP_DIV128 = 10'h07f;
  localparam logic [9:0] TAP_DIV256 = 10'h0ff;
  localparam logic [9:0] TAP_DIV1024 = 10'h3ff;
  localparam logic [9:0] PRESCALE_RESET = 10'h000;

  // ****************************************
  // Bus constants
  // ****************************************
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_WRITE = 2'b01,
    PH_READ = 2'b10
  } bus_phase_t;

  typedef struct packed {
    logic [9:0] count;
  } prescale_state_t;

  typedef struct packed {
    logic oscMeta;
    logic oscSync;
    logic oscLast;
    bus_phase_t phase;
    logic [7:0] addrIdx;
    logic hreadyout;
    logic [31:0] hrdata;
    logic [4:0][7:0] live;
    logic [4:0][7:0] stage;
    logic [4:0] busy;
    logic [4:0] ack;
    logic [2:0] irqFlags;
    logic [2:0] irqMask;
    logic extClockEnable;
    logic asyncSelect;
    logic syncHold;
    logic asyncPrescalerReset;
    logic syncPrescalerReset;
    logic countDown;
    logic blockMatch;
    logic waveOutA;
    logic waveOutB;
    logic [2:0] irqRequest;
    logic crystalRun;
    logic extClockBuffer;
  } timer_state_t;

endpackage

// ### core/timer_prescaler.sv
`timescale 1ns/10ps
module timer_prescaler (
  input wire logic sysClk,
  input wire logic srst,
  input wire logic srcTick,
  input wire logic prescalerClear,
  input wire logic [2:0] clockSelect,
  output logic timerTick
);

  timer_async_pkg::prescale_state_t stateReg;
  timer_async_pkg::prescale_state_t stateNext;
  logic [9:0] tapMask;
  logic tapHit;

  // ****************************************
  // Tap selection
  // ****************************************
  always_comb begin
    tapMask = timer_async_pkg::TAP_DIV1024;
    tapHit = 1'b0;
    unique case (clockSelect)
      timer_async_pkg::CS_STOPPED: tapHit = 1'b0;
      timer_async_pkg::CS_DIRECT: tapHit = 1'b1;
      timer_async_pkg::CS_DIV8: tapMask = timer_async_pkg::TAP_DIV8;
      timer_async_pkg::CS_DIV32: tapMask = timer_async_pkg::TAP_DIV32;
      timer_async_pkg::CS_DIV64: tapMask = timer_async_pkg::TAP_DIV64;
      timer_async_pkg::CS_DIV128: tapMask = timer_async_pkg::TAP_DIV128;
      timer_async_pkg::CS_DIV256: tapMask = timer_async_pkg::TAP_DIV256;
      timer_async_pkg::CS_DIV1024: tapMask = timer_async_pkg::TAP_DIV1024;
    endcase
    if (clockSelect > timer_async_pkg::CS_DIRECT) begin
      tapHit = (stateReg.count & tapMask) == tapMask;
    end
    timerTick = srcTick & ~prescalerClear & tapHit;
  end

  // ****************************************
  // Prescaler counter
  // ****************************************
  always_comb begin
    stateNext = stateReg;
    if (prescalerClear) begin
      stateNext.count = timer_async_pkg::PRESCALE_RESET;
    end else if (srcTick) begin
      stateNext.count = stateReg.count + 10'h001;
    end
  end

  always_ff @(posedge sysClk) begin
    if (srst) begin
      stateReg.count <= timer_async_pkg::PRESCALE_RESET;
    end else begin
      stateReg <= stateNext;
    end
  end

endmodule

// ### core/async_timer_control.sv
// Our own choice: register access over AHB-Lite.
`timescale 1ns/10ps
// How it works
// - Clock select: stop, direct, or prescaler taps
// - Counter read/write; write blocks next match
// - Two compares vs counter drive flag, pin
// - External clock buffer; crystal runs when disabled
// - Async select picks I/O or oscillator clock
// - Async writes set busy until transferred
// - Counter reads live; others read staging
// - Mask bits gate flags with global enable
// - Compare flags set on counter match
// - Flags cleared by vector or writing one
// - Overflow flag; phase correct PWM sets at bottom turn
// - Prescaler reset bit, self clearing normally
// - Async prescaler reset waits for oscillator edge
// - Sync hold keeps prescaler reset pending
module async_timer_control (
  input wire logic sysClk,
  input wire logic srst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic timerOscInput,
  input wire logic globalIrqEnable,
  input wire logic [2:0] irqVectorAck,
  output logic [2:0] irqRequest,
  output logic waveformOutA,
  output logic waveformOutB,
  output logic crystalOscRun,
  output logic extClockBufferEnable
);

  timer_async_pkg::timer_state_t r;
  timer_async_pkg::timer_state_t n;
  logic oscRise;
  logic srcTick;
  logic timerTick;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic [7:0] cnt;
  logic [7:0] nextCnt;
  logic [7:0] topValue;
  logic [2:0] wgmMode;
  logic phaseCorrect;
  logic fastPwm;
  logic matchA;
  logic matchB;
  logic overflow;
  logic wrapBottom;
  logic [4:0] transfer;

  // Output compare pin update for one channel
  function automatic logic waveNext(
    input logic cur,
    input logic [1:0] com,
    input logic match,
    input logic pwm,
    input logic down,
    input logic bottom
  );
    logic v;
    v = cur;
    if (com != 2'b00) begin
      if (!pwm) begin
        if (match) begin
          v = (com == 2'b01) ? ~cur : com[0];
        end
      end else if (com != 2'b01) begin
        if (match) begin
          v = com[0] ^ down;
        end else if (bottom) begin
          v = ~com[0];
        end
      end
    end
    return v;
  endfunction

  // ****************************************
  // Timer clock source
  // ****************************************
  // select source; oscillator edge is one enable pulse
  assign oscRise = r.oscSync & ~r.oscLast;
  assign srcTick = r.asyncSelect ? oscRise : 1'b1;

  timer_prescaler prescaler (
    .sysClk(sysClk),
    .srst(srst),
    .srcTick(srcTick),
    .prescalerClear(r.asyncPrescalerReset),
    .clockSelect(r.live[timer_async_pkg::SLOT_CONTROL_B][2:0]),
    .timerTick(timerTick)
  );

  // ****************************************
  // Counter and compare datapath
  // ****************************************
  always_comb begin
    cnt = r.live[timer_async_pkg::SLOT_COUNTER];
    wgmMode = {r.live[timer_async_pkg::SLOT_CONTROL_B]
      [timer_async_pkg::BIT_WGM_HIGH],
      r.live[timer_async_pkg::SLOT_CONTROL_A][1:0]};
    phaseCorrect = wgmMode[1:0] == 2'b01;
    fastPwm = wgmMode[1:0] == 2'b11;
    topValue = wgmMode[2] ? r.live[timer_async_pkg::SLOT_COMPARE_A]
      : timer_async_pkg::COUNTER_MAX;
    nextCnt = cnt + 8'h01;
    overflow = 1'b0;
    wrapBottom = 1'b0;
    if (phaseCorrect) begin
      if (!r.countDown) begin
        if (cnt == topValue) begin
          nextCnt = cnt - 8'h01;
        end
      end else if (cnt == timer_async_pkg::COUNTER_BOTTOM) begin
        // overflow at direction change in PWM
        overflow = 1'b1;
      end else begin
        nextCnt = cnt - 8'h01;
      end
    end else begin
      if (cnt == topValue) begin
        nextCnt = timer_async_pkg::COUNTER_BOTTOM;
        wrapBottom = 1'b1;
      end
      // overflow when the counter is at its maximum, or at compare A TOP in fast PWM
      overflow = (fastPwm && wgmMode[2]) ? (cnt == topValue)
        : (cnt == timer_async_pkg::COUNTER_MAX);
    end
    // continuous compare; match blocked after write
    matchA = (cnt == r.live[timer_async_pkg::SLOT_COMPARE_A])
      & ~r.blockMatch;
    matchB = (cnt == r.live[timer_async_pkg::SLOT_COMPARE_B])
      & ~r.blockMatch;
  end

  // ****************************************
  // Register read mux
  // ****************************************
  always_comb begin
    rdata = 8'h00;
    unique case (r.addrIdx)
      timer_async_pkg::IDX_IRQ_FLAGS: rdata = {5'h00, r.irqFlags};
      timer_async_pkg::IDX_IRQ_MASK: rdata = {5'h00, r.irqMask};
      timer_async_pkg::IDX_GENERAL_CTRL: begin
        rdata = {r.syncHold, 5'h00, r.asyncPrescalerReset,
          r.syncPrescalerReset};
      end
      timer_async_pkg::IDX_ASYNC_STATUS: begin
        rdata = {1'b0, r.extClockEnable, r.asyncSelect, r.busy};
      end
      timer_async_pkg::IDX_COUNTER: begin
        rdata = r.live[timer_async_pkg::SLOT_COUNTER];
      end
      timer_async_pkg::IDX_COMPARE_A: begin
        rdata = r.stage[timer_async_pkg::SLOT_COMPARE_A];
      end
      timer_async_pkg::IDX_COMPARE_B: begin
        rdata = r.stage[timer_async_pkg::SLOT_COMPARE_B];
      end
      timer_async_pkg::IDX_CONTROL_A: begin
        rdata = r.stage[timer_async_pkg::SLOT_CONTROL_A];
      end
      timer_async_pkg::IDX_CONTROL_B: begin
        rdata = r.stage[timer_async_pkg::SLOT_CONTROL_B];
      end
      default: rdata = 8'h00;
    endcase
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    n = r;
    wdata = hwdata[7:0];
    transfer = 5'h00;
    n.oscMeta = timerOscInput;
    n.oscSync = r.oscMeta;
    n.oscLast = r.oscSync;

    // busy falls one cycle after the transfer acknowledge
    n.busy = r.busy & ~r.ack;
    n.ack = 5'h00;
    if (r.asyncSelect && oscRise) begin
      transfer = r.busy & ~r.ack;
    end
    for (int s = 0; s < 5; s++) begin
      if (transfer[s]) begin
        // staging moves over on the oscillator edge
        n.live[s] = r.stage[s];
        n.ack[s] = 1'b1;
        if (s == timer_async_pkg::SLOT_COUNTER) begin
          n.blockMatch = 1'b1;
        end
      end
    end

    if (r.asyncPrescalerReset && !r.syncHold) begin
      // async reset held until an oscillator edge
      if (!r.asyncSelect || oscRise) begin
        // cleared by hardware on the oscillator edge, or after one cycle when not async
        n.asyncPrescalerReset = 1'b0;
      end
    end
    if (!r.syncHold) begin
      n.syncPrescalerReset = 1'b0;
    end

    // Timer tick
    if (timerTick && (transfer[timer_async_pkg::SLOT_COUNTER] == 1'b0)) begin
      n.live[timer_async_pkg::SLOT_COUNTER] = nextCnt;
      n.blockMatch = 1'b0;
      if (phaseCorrect) begin
        if (!r.countDown && cnt == topValue) begin
          n.countDown = 1'b1;
        end else if (r.countDown && overflow) begin
          n.countDown = 1'b0;
        end
      end else begin
        n.countDown = 1'b0;
      end
      n.waveOutA = waveNext(r.waveOutA,
        r.live[timer_async_pkg::SLOT_CONTROL_A][7:6], matchA,
        phaseCorrect | fastPwm, r.countDown, wrapBottom & fastPwm);
      n.waveOutB = waveNext(r.waveOutB,
        r.live[timer_async_pkg::SLOT_CONTROL_A][5:4], matchB,
        phaseCorrect | fastPwm, r.countDown, wrapBottom & fastPwm);
    end

    n.irqFlags = r.irqFlags & ~irqVectorAck;

    // Bus data phase write
    if (r.phase == timer_async_pkg::PH_WRITE) begin
      unique case (r.addrIdx)
        timer_async_pkg::IDX_IRQ_FLAGS: begin
          n.irqFlags = n.irqFlags & ~wdata[2:0];
        end
        timer_async_pkg::IDX_IRQ_MASK: n.irqMask = wdata[2:0];
        timer_async_pkg::IDX_GENERAL_CTRL: begin
          n.syncHold = wdata[timer_async_pkg::BIT_SYNC_HOLD];
          if (wdata[timer_async_pkg::BIT_ASYNC_PRESCALER_RESET]) begin
            n.asyncPrescalerReset = 1'b1;
          end
          if (wdata[timer_async_pkg::BIT_SYNC_PRESCALER_RESET]) begin
            n.syncPrescalerReset = 1'b1;
          end
        end
        timer_async_pkg::IDX_ASYNC_STATUS: begin
          n.extClockEnable = wdata[timer_async_pkg::BIT_EXT_CLOCK_ENABLE];
          n.asyncSelect = wdata[timer_async_pkg::BIT_ASYNC_SELECT];
        end
        default: begin
        end
      endcase
      for (int s = 0; s < 5; s++) begin
        logic hit;
        logic [7:0] v;
        hit = 1'b0;
        v = wdata;
        unique case (s)
          timer_async_pkg::SLOT_COUNTER: begin
            hit = r.addrIdx == timer_async_pkg::IDX_COUNTER;
          end
          timer_async_pkg::SLOT_COMPARE_A: begin
            hit = r.addrIdx == timer_async_pkg::IDX_COMPARE_A;
          end
          timer_async_pkg::SLOT_COMPARE_B: begin
            hit = r.addrIdx == timer_async_pkg::IDX_COMPARE_B;
          end
          timer_async_pkg::SLOT_CONTROL_A: begin
            hit = r.addrIdx == timer_async_pkg::IDX_CONTROL_A;
            v = wdata & timer_async_pkg::CONTROL_A_MASK;
          end
          default: begin
            hit = r.addrIdx == timer_async_pkg::IDX_CONTROL_B;
            v = wdata & timer_async_pkg::CONTROL_B_MASK;
          end
        endcase
        if (hit) begin
          n.stage[s] = v;
          if (r.asyncSelect) begin
            // async write sets the busy flag
            n.busy[s] = 1'b1;
            n.ack[s] = 1'b0;
          end else begin
            n.live[s] = v;
            if (s == timer_async_pkg::SLOT_COUNTER) begin
              n.blockMatch = 1'b1;
            end
          end
        end
      end
    end

    // compare flags set on match, overflow flag on overflow; set wins over clear
    if (timerTick) begin
      if (matchA) begin
        n.irqFlags[timer_async_pkg::BIT_COMPARE_A] = 1'b1;
      end
      if (matchB) begin
        n.irqFlags[timer_async_pkg::BIT_COMPARE_B] = 1'b1;
      end
      if (overflow) begin
        n.irqFlags[timer_async_pkg::BIT_OVERFLOW] = 1'b1;
      end
    end

    // request needs enable, global bit and flag
    n.irqRequest = r.irqFlags & r.irqMask & {3{globalIrqEnable}};
    // buffer on external clock with async select; crystal when external clock is off
    n.crystalRun = ~r.extClockEnable;
    n.extClockBuffer = r.extClockEnable & r.asyncSelect;

    // Bus protocol
    n.hreadyout = 1'b1;
    if (r.phase == timer_async_pkg::PH_READ && !r.hreadyout) begin
      n.hrdata = {24'h000000, rdata};
      n.phase = timer_async_pkg::PH_IDLE;
    end else begin
      n.phase = timer_async_pkg::PH_IDLE;
      if (hsel && hready && htrans == timer_async_pkg::HTRANS_NONSEQ) begin
        n.addrIdx = haddr[9:2];
        if (hwrite) begin
          n.phase = timer_async_pkg::PH_WRITE;
        end else begin
          n.phase = timer_async_pkg::PH_READ;
          n.hreadyout = 1'b0;
        end
      end
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge sysClk) begin
    if (srst) begin
      r <= '0;
      r.phase <= timer_async_pkg::PH_IDLE;
      r.hreadyout <= 1'b1;
      r.hrdata <= timer_async_pkg::RESET_RDATA;
      r.crystalRun <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign hrdata = r.hrdata;
  assign hreadyout = r.hreadyout;
  assign hresp = 1'b0;
  assign irqRequest = r.irqRequest;
  assign waveformOutA = r.waveOutA;
  assign waveformOutB = r.waveOutB;
  assign crystalOscRun = r.crystalRun;
  assign extClockBufferEnable = r.extClockBuffer;

endmodule

// ### dv/async_timer_control_assertions.sv
`timescale 1ns/10ps
module async_timer_control_assertions (
  input wire logic sysClk,
  input wire logic srst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic globalIrqEnable,
  input wire logic [2:0] irqRequest,
  input wire logic crystalOscRun,
  input wire logic extClockBufferEnable
);
  // ****************************************
  // Shadow of mask and async status writes
  // ****************************************
  logic take;
  logic wrData;
  logic apVld;
  logic apWr;
  logic [7:0] apIdx;
  logic [7:0] maskSh;
  logic [7:0] statSh;
  assign take = hsel && hready && htrans == timer_async_pkg::HTRANS_NONSEQ;
  assign wrData = apVld && apWr && hready;
  always_ff @(posedge sysClk) begin
    if (srst) begin
      apVld <= 1'b0;
      maskSh <= 8'h00;
      statSh <= 8'h00;
    end else begin
      if (hready) begin
        apVld <= take;
        apWr <= hwrite;
        apIdx <= haddr[9:2];
      end
      if (wrData && apIdx == timer_async_pkg::IDX_IRQ_MASK) begin
        maskSh <= hwdata[7:0];
      end
      if (wrData && apIdx == timer_async_pkg::IDX_ASYNC_STATUS) begin
        statSh <= hwdata[7:0];
      end
    end
  end
  default clocking cb @(posedge sysClk);
  endclocking
  default disable iff (srst);
  // ****************************************
  // Properties
  // ****************************************
  property p_read_wait;
    take && !hwrite |=> !hreadyout ##1 hreadyout;
  endproperty
  a_read_wait: assert property (p_read_wait)
    else $error("read wait state wrong");
  property p_stall_cause;
    !hreadyout |-> $past(take && !hwrite);
  endproperty
  a_stall_cause: assert property (p_stall_cause)
    else $error("stall without read");
  property p_write_nostall;
    take && hwrite |=> hreadyout;
  endproperty
  a_write_nostall: assert property (p_write_nostall)
    else $error("write stalled");
  property p_rdata_hold;
    hreadyout && $past(hreadyout) |-> $stable(hrdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data moved");
  property p_rdata_byte;
    $rose(hreadyout) |-> hrdata[31:8] == 24'h000000;
  endproperty
  a_rdata_byte: assert property (p_rdata_byte)
    else $error("upper read bits set");
  property p_irq_gate;
    irqRequest != 3'h0 |-> $past(globalIrqEnable) &&
      (irqRequest & ~$past(maskSh[2:0])) == 3'h0;
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("request not gated");
  property p_buf_xtal;
    extClockBufferEnable |-> !crystalOscRun;
  endproperty
  a_buf_xtal: assert property (p_buf_xtal)
    else $error("crystal runs with external clock");
  property p_pins;
    statSh == $past(statSh) && statSh == $past(statSh, 2) |->
      crystalOscRun == !statSh[6] &&
      extClockBufferEnable == (statSh[6] && statSh[5]);
  endproperty
  a_pins: assert property (p_pins)
    else $error("clock pins wrong");
endmodule

bind async_timer_control async_timer_control_assertions chk (
  .sysClk, .srst, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
  .hrdata, .hreadyout, .globalIrqEnable, .irqRequest, .crystalOscRun,
  .extClockBufferEnable
);

// ### dv/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  typedef struct {string name; logic [7:0] exp; logic chk;} note_t;
  logic sysClk, srst, hsel, hwrite, timerOscInput, oscOn, lowSeen;
  logic globalIrqEnable, hreadyout, hresp, waveformOutA, waveformOutB;
  logic crystalOscRun, extClockBufferEnable;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] irqVectorAck, irqRequest;
  logic [7:0] rdVal, v;
  int fail_count, n_tests, cnt, lo, hi;
  int divs[8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
  logic [7:0] slot[5] = '{8'hb0, 8'hb1, 8'hb2, 8'hb3, 8'hb4};
  logic [7:0] busyBit[5] = '{8'h02, 8'h01, 8'h10, 8'h08, 8'h04};
  logic [7:0] slotData[5] = '{8'h00, 8'h00, 8'h00, 8'h33, 8'h44};
  note_t expQ[$];

  async_timer_control dut (.sysClk(sysClk), .srst(srst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .timerOscInput(timerOscInput),
    .globalIrqEnable(globalIrqEnable), .irqVectorAck(irqVectorAck),
    .irqRequest(irqRequest), .waveformOutA(waveformOutA),
    .waveformOutB(waveformOutB), .crystalOscRun(crystalOscRun),
    .extClockBufferEnable(extClockBufferEnable));

  // ****************************************
  // Clock, oscillator pin and watchdog
  // ****************************************
  initial begin
    sysClk = 1'b0;
    forever #4 sysClk = ~sysClk;
  end
  always begin
    repeat (7) @(posedge sysClk);
    if (oscOn) timerOscInput <= ~timerOscInput;
  end
  initial begin
    repeat (80000) @(posedge sysClk);
    fail_count++;
    end_sim();
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic check(input string name, input logic [7:0] seen,
                       input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic bus(input logic [7:0] idx, input logic wr,
                     input logic [7:0] wd);
    htrans <= timer_async_pkg::HTRANS_NONSEQ;
    haddr <= {22'h0, idx, 2'b00};
    hwrite <= wr;
    do @(posedge sysClk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    do @(posedge sysClk); while (hreadyout !== 1'b1);
    rdVal = hrdata[7:0];
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    bus(idx, 1'b1, d);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] e,
                    input string name, input logic chk = 1'b1);
    expQ.push_back('{name, e, chk});
    bus(idx, 1'b0, 8'h00);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sysClk);
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Read data is compared at the edge that ends the data phase, the first edge after the wait state where hreadyout is high
  always @(posedge sysClk) begin
    note_t n;
    if (lowSeen && hreadyout === 1'b1 && expQ.size() > 0) begin
      n = expQ.pop_front();
      if (n.chk) check(n.name, hrdata[7:0], n.exp);
      check("hresp", {7'h0, hresp}, 8'h00);
    end
    lowSeen <= (hreadyout === 1'b0);
  end

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    hsel = 1'b1;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    srst = 1'b1;
    oscOn = 1'b0;
    timerOscInput = 1'b0;
    globalIrqEnable = 1'b0;
    irqVectorAck = 3'h0;
    lowSeen = 1'b0;
    void'($urandom(56040));
    repeat (3) @(posedge sysClk);
    srst <= 1'b0;
    foreach (slot[i]) rd(slot[i], 8'h00, "reset value");
    rd(8'h37, 8'h00, "reset flags");
    rd(8'h43, 8'h00, "reset general");
    rd(8'h70, 8'h00, "reset mask");
    rd(8'hb6, 8'h00, "reset status");
    wr(8'h00, 8'hff);
    rd(8'h00, 8'h00, "unmapped");
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      v = 8'($urandom);
      wr(8'h70, v);
      rd(8'h70, v & 8'h07, "mask rw");
      wr(8'hb0, v);
      rd(8'hb0, v & 8'hf3, "control a rw");
      wr(8'hb1, v & 8'hf8);
      rd(8'hb1, v & 8'h08, "control b rw");
      wr(8'hb3, v);
      rd(8'hb3, v, "compare a rw");
      wr(8'hb4, ~v);
      rd(8'hb4, ~v, "compare b rw");
    end
    wr(8'hb0, 8'h00);
    wr(8'hb1, 8'h00);
    $display("test registers done");
    wr(8'hb3, 8'h80);
    wr(8'hb4, 8'hc0);
    wr(8'h70, 8'h07);
    wr(8'hb0, 8'h70);
    globalIrqEnable <= 1'b1;
    wr(8'hb1, 8'h01);
    tick(300);
    wr(8'hb1, 8'h00);
    rd(8'h37, 8'h07, "flags set");
    tick(2);
    check("irq all", {5'h0, irqRequest}, 8'h07);
    check("wave a toggled", {7'h0, waveformOutA}, 8'h01);
    check("wave b set", {7'h0, waveformOutB}, 8'h01);
    wr(8'h37, 8'h02);
    rd(8'h37, 8'h05, "write one clear");
    irqVectorAck <= 3'h1;
    @(posedge sysClk);
    irqVectorAck <= 3'h0;
    rd(8'h37, 8'h04, "vector clear");
    tick(2);
    check("irq b", {5'h0, irqRequest}, 8'h04);
    globalIrqEnable <= 1'b0;
    tick(2);
    check("irq global off", {5'h0, irqRequest}, 8'h00);
    globalIrqEnable <= 1'b1;
    wr(8'h70, 8'h03);
    tick(2);
    check("irq masked", {5'h0, irqRequest}, 8'h00);
    $display("test flags done");
    for (int j = 0; j < 2; j++) begin
      wr(8'hb3, 8'h40);
      wr(8'hb2, 8'h40 - 8'(j));
      wr(8'h37, 8'h07);
      wr(8'hb1, 8'h01);
      tick(3);
      wr(8'hb1, 8'h00);
      rd(8'h37, {6'h0, j[0], 1'b0}, "match after write");
    end
    $display("test counter write done");
    for (int c = 1; c < 8; c++) begin
      wr(8'hb2, 8'h00);
      wr(8'h43, 8'h02);
      wr(8'hb1, 8'(c));
      tick(20 * divs[c]);
      wr(8'hb1, 8'h00);
      rd(8'hb2, 8'h00, "count", 1'b0);
      cnt = rdVal;
      lo = 19;
      hi = 21 + 6 / divs[c];
      check("count range", {7'h0, cnt >= lo && cnt <= hi}, 8'h01);
      rd(8'h43, 8'h00, "prescaler reset clear");
    end
    wr(8'h43, 8'h82);
    tick(4);
    rd(8'h43, 8'h82, "sync hold keeps reset");
    wr(8'h43, 8'h02);
    tick(4);
    rd(8'h43, 8'h00, "reset released");
    $display("test prescaler done");
    wr(8'hb6, 8'h40);
    wr(8'hb6, 8'h60);
    tick(3);
    check("crystal", {7'h0, crystalOscRun}, 8'h00);
    check("ext buffer", {7'h0, extClockBufferEnable}, 8'h01);
    v = 8'h60;
    foreach (slot[i]) begin
      wr(slot[i], slotData[i]);
      v = v | busyBit[i];
      rd(8'hb6, v, "busy set");
    end
    rd(8'hb3, 8'h33, "staged compare");
    wr(8'h43, 8'h02);
    tick(4);
    rd(8'h43, 8'h02, "async reset pending");
    oscOn <= 1'b1;
    tick(80);
    rd(8'hb6, 8'h60, "busy clear");
    rd(8'h43, 8'h00, "async reset done");
    wr(8'hb1, 8'h01);
    tick(200);
    wr(8'hb1, 8'h00);
    tick(60);
    rd(8'hb2, 8'h00, "async count", 1'b0);
    cnt = rdVal;
    check("async count", {7'h0, cnt >= 10 && cnt <= 17}, 8'h01);
    $display("test async done");
    end_sim();
  end
endmodule
